/* dv/interrupt_system_entry_tb.sv */
// Bench for the interrupt entry logic: register port tasks, a core
// model for instruction ends, and directed interrupt scenarios.
// Assumes a 100 MHz clock and reset held low for 10 cycles.
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
   $display("mismatch t=%0t got=%0h exp=%0h", $time, a, e); end end
module interrupt_system_entry_tb;
   import ise_pkg::*;
   logic core_clk = 0, rstn = 0, ce = 1, sfr_wr = 0, sfr_rd = 0, sfr_bit_wr = 0, sfr_bit_val = 0;
   logic t2l = 0, t2h = 0, go_instr = 0, go_ret = 0, multi = 0, slow = 0, sw_clr = 0, vc;
   logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_bit_addr = 0, ext1 = 0, ext2 = 0, rdv, sfr_rdata, page, ien;
   logic [NSRC*LVL_W-1:0] src_prio = '0;
   logic [NSRC-1:0] src_evt = '0, pend_clr, pending;
   logic irq_req, vector_call, instr_done, nmc, return_from_isr;
   logic [15:0] vec_addr;
   logic [SID_W-1:0] src_id;
   logic [DEP_W-1:0] depth;
   int mismatches = 0, n_tests = 0, cyc = 0, j;

   always #5 core_clk = ~core_clk;

   // Cycle ceiling so a stuck handshake still ends the run
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         end_sim();
      end
   end

   ise_core u_dut (
      .core_clk, .rstn, .ce, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata, .sfr_bit_wr,
      .sfr_bit_addr, .sfr_bit_val, .extended_enable_reg_one(ext1), .extended_enable_reg_two(ext2),
      .src_prio, .src_evt, .timer2_low_overflow_flag(t2l), .timer2_high_overflow_flag(t2h),
      .pend_clr, .instr_done, .next_multi_cycle(nmc), .return_from_isr, .irq_req, .vector_call, .vec_addr,
      .src_id, .pending, .register_page_select(page), .page_stack_index(depth), .interrupt_enable_reg(ien));
   ise_cpu_model u_cpu (
      .core_clk, .rstn, .go_instr, .go_ret, .multi, .slow, .sw_clr, .vector_call, .src_id,
      .instr_done, .next_multi_cycle(nmc), .return_from_isr, .pend_clr);

   ////////////////////////////////////////////////////////////////////////////////
   // Inputs move 1 ns after the edge so the design samples settled values
   task automatic tick();
      @(posedge core_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1;
      tick();
      sfr_wr = 0;
   endtask
   task automatic bw(input int b, input logic v);
      sfr_bit_addr = EN_REG_ADDR + 8'(b);
      sfr_bit_val = v;
      sfr_bit_wr = 1;
      tick();
      sfr_bit_wr = 0;
   endtask
   task automatic rd(input logic [7:0] a);
      sfr_addr = a;
      sfr_rd = 1;
      tick();
      sfr_rd = 0;
      rdv = sfr_rdata;
   endtask
   task automatic evt(input logic [NSRC-1:0] m);
      src_evt = m;
      tick();
      src_evt = '0;
   endtask
   // Ends one instruction; vc tells whether a call followed it
   task automatic instr(input logic m);
      multi = m;
      go_instr = 1;
      tick();
      go_instr = 0;
      for (int k = 0; k < 8 && instr_done !== 1'b1; k++) tick();
      tick();
      vc = vector_call;
   endtask
   task automatic leave_isr();
      go_ret = 1;
      tick();
      go_ret = 0;
      tick();
      tick();
   endtask
   task automatic serve(input int s);
      instr(1'b0);
      `CHK(vc, 1'b1)
      `CHK(src_id, SID_W'(s))
      `CHK(vec_addr, VEC_BASE + VEC_STEP * 16'(s))
      leave_isr();
   endtask
   // Enable cleared one cycle before an instruction ends (prompt core only)
   task automatic slip(input logic m);
      multi = m;
      go_instr = 1;
      tick();
      go_instr = 0;
      bw(GLOBAL_EN_BIT, 1'b0);
      tick();
      vc = vector_call;
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge core_clk);
      #1 rstn = 1;
      tick();
      // Reset values, byte access and an unmapped address
      `CHK(ien, EN_REG_RST)
      `CHK(page, PAGE_RST)
      wr(8'h3C, 8'hFF);
      rd(8'h3C);
      `CHK(rdv, 8'h00)
      wr(EN_REG_ADDR, 8'h7F);
      rd(EN_REG_ADDR);
      `CHK(rdv, 8'h7F)
      // Clock enable low freezes the register and the flags
      ce = 0;
      wr(EN_REG_ADDR, 8'h55);
      evt(23'h1);
      `CHK(ien, 8'h7F)
      `CHK(pending[0], 1'b0)
      ce = 1;
      $display("test registers done");
      // Flag latches while masked; global off and own bit off both block
      evt(23'h2);
      `CHK(pending[1], 1'b1)
      instr(1'b0);
      `CHK(vc, 1'b0)
      wr(EN_REG_ADDR, 8'hFD);
      instr(1'b0);
      `CHK(vc, 1'b0)
      wr(PAGE_SEL_ADDR, 8'h0F);
      bw(1, 1'b1);
      `CHK(ien, 8'hFF)
      serve(1);
      `CHK(pending[1], 1'b0)
      `CHK(page, 8'h0F)
      `CHK(depth, 3'h0)
      $display("test masking done");
      // Page push on entry seen inside the routine
      evt(23'h2);
      instr(1'b0);
      `CHK(page, ISR_PAGE)
      `CHK(depth, 3'h1)
      leave_isr();
      `CHK(page, 8'h0F)
      // Sources 0-7 and 22 each through its own enable bit; pass 7 is timer 2 by its high flag
      sw_clr = 1;
      for (int i = 0; i < 10; i++) begin
         j = (i == 7) ? 5 : (i == 8) ? 7 : (i == 9) ? 22 : i;
         ext1 = (i == 8) ? 8'h01 : 8'h00;
         ext2 = (i == 9) ? 8'h80 : 8'h00;
         wr(EN_REG_ADDR, 8'h80 | (j < 7 ? 8'(1 << j) : 8'h00));
         slow = i[0];
         if (i == 5 || i == 7) begin
            t2l = (i == 5);
            t2h = (i == 7);
            tick();
            t2l = 0;
            t2h = 0;
         end else
            evt(NSRC'(1) << j);
         serve(j);
         `CHK(pending[j], 1'b0)
      end
      slow = 0;
      $display("test source map done");
      // Higher level wins and blocks lower; equal levels go to the lower index
      wr(EN_REG_ADDR, 8'hD0);
      src_prio[13:12] = 2'h2;
      src_prio[9:8] = 2'h1;
      evt(23'h50);
      instr(1'b0);
      `CHK(src_id, SID_W'(6))
      instr(1'b0);
      `CHK(vc, 1'b0)
      leave_isr();
      serve(4);
      // Higher level nests inside the routine of a lower one
      evt(23'h10);
      instr(1'b0);
      `CHK(depth, 3'h1)
      evt(23'h40);
      instr(1'b0);
      `CHK(vc, 1'b1)
      `CHK(src_id, SID_W'(6))
      `CHK(depth, 3'h2)
      leave_isr();
      `CHK(depth, 3'h1)
      leave_isr();
      `CHK(depth, 3'h0)
      src_prio = '0;
      evt(23'h50);
      serve(4);
      serve(6);
      $display("test priority done");
      // Flag left set at return re-enters after one instruction
      sw_clr = 0;
      evt(23'h10);
      serve(4);
      sw_clr = 1;
      serve(4);
      instr(1'b0);
      `CHK(vc, 1'b0)
      // Enable cleared while a request stands: taken only before a short instruction
      evt(23'h10);
      tick();
      `CHK(irq_req, 1'b1)
      slip(1'b1);
      `CHK(vc, 1'b0)
      wr(EN_REG_ADDR, 8'hD0);
      tick();
      slip(1'b0);
      `CHK(vc, 1'b1)
      rd(EN_REG_ADDR);
      `CHK(rdv, 8'h50)
      leave_isr();
      `CHK(pending[4], 1'b0)
      $display("test slip done");
      end_sim();
   end
endmodule

/* dv/ise_cpu_model.sv */
// CPU core model: ends instructions and returns on bench command,
// and clears flags that hardware leaves set, as a routine would.
// Assumes one command at a time from the bench.
`timescale 1ns/1ps
module ise_cpu_model (
   input  wire logic                      core_clk,
   input  wire logic                      rstn,
   input  wire logic                      go_instr,
   input  wire logic                      go_ret,
   input  wire logic                      multi,
   input  wire logic                      slow,
   input  wire logic                      sw_clr,
   input  wire logic                      vector_call,
   input  wire logic [ise_pkg::SID_W-1:0] src_id,
   output logic                           instr_done,
   output logic                           next_multi_cycle,
   output logic                           return_from_isr,
   output logic      [ise_pkg::NSRC-1:0]  pend_clr
);
   import ise_pkg::*;
   logic [1:0] cnt_q;

   // Next instruction length comes from the bench; a two-byte follower is multi-cycle
   assign next_multi_cycle = multi;

   // Instruction ends one or three cycles after its command (prompt or slow core)
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q      <= 2'h0;
         instr_done <= 1'b0;
      end else begin
         cnt_q      <= go_instr ? (slow ? 2'h3 : 2'h1) : cnt_q - {1'b0, |cnt_q};
         instr_done <= (cnt_q == 2'h1);
      end
   end

   // Return ends a cycle after its command; routine clears a flag hardware kept
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         return_from_isr <= 1'b0;
         pend_clr  <= '0;
      end else begin
         return_from_isr <= go_ret;
         pend_clr  <= (vector_call && sw_clr && !AUTO_CLR[src_id]) ? NSRC'(1) << src_id : '0;
      end
   end
endmodule

/* rtl/ise_core.sv */
// Interrupt request latching, masking, priority pick, vector call
// and register-page stack for a small microcontroller core.
// Assumes the core pulses instr_done at each instruction end and
// return_from_isr at the end of a return from interrupt, never both.
//
// Function
// R01 - A source event sets its pending flag regardless of enables.
// R02 - Enabled pending source requests a call to its vector after current instruction.
// R03 - Return from routine resumes the instruction that would have run next.
// R04 - A pending flag of a disabled source raises no request.
// R05 - Every source has its own enable bit in main or extended registers.
// R06 - Global enable low blocks every source.
// R07 - Each source carries one of four priority levels.
// R08 - Request during enable clear taken only before a single-cycle instruction.
// R09 - Software follows an enable clear with a two-byte instruction.
// R10 - A cleared enable bit reads back zero inside the routine.
// R11 - Some flags clear on vectoring; software clears the rest.
// R12 - Flag still set after return re-enters after one more instruction.
// R13 - Enable bit 5 unmasks timer 2, low or high overflow.
// R14 - Bits 2 and 0 unmask external lines 1 and 0.
// R15 - Bits 3 and 1 unmask timer 1 and timer 0 overflow.
// R16 - Bit 6 unmasks the serial peripheral, bit 4 the UART.
// R17 - Main enable register is on every page and bit-writable.
// R18 - Vectoring pushes the page selector and loads the routine's page.
// R19 - Page select is stack top and writable any time; here a write in the same cycle as a vector call or a return is lost.
// R20 - Highest level wins; lowest source index breaks ties.
// R21 - Return pops the page stack, restoring the prior page.
`timescale 1ns/1ps
module ise_core
   import ise_pkg::*;
(
   input  wire logic                           core_clk,
   input  wire logic                           rstn,
   input  wire logic                           ce,
   input  wire logic [7:0]                     sfr_addr,
   input  wire logic                           sfr_wr,
   input  wire logic [7:0]                     sfr_wdata,
   input  wire logic                           sfr_rd,
   output logic      [7:0]                     sfr_rdata,
   input  wire logic                           sfr_bit_wr,
   input  wire logic [7:0]                     sfr_bit_addr,
   input  wire logic                           sfr_bit_val,
   input  wire logic [7:0]                     extended_enable_reg_one,
   input  wire logic [7:0]                     extended_enable_reg_two,
   input  wire logic [ise_pkg::NSRC*ise_pkg::LVL_W-1:0] src_prio,
   input  wire logic [ise_pkg::NSRC-1:0]       src_evt,
   input  wire logic                           timer2_low_overflow_flag,
   input  wire logic                           timer2_high_overflow_flag,
   input  wire logic [ise_pkg::NSRC-1:0]       pend_clr,
   input  wire logic                           instr_done,
   input  wire logic                           next_multi_cycle,
   input  wire logic                           return_from_isr,
   output logic                                irq_req,
   output logic                                vector_call,
   output logic      [15:0]                    vec_addr,
   output logic      [ise_pkg::SID_W-1:0]      src_id,
   output logic      [ise_pkg::NSRC-1:0]       pending,
   output logic      [7:0]                     register_page_select,
   output logic      [ise_pkg::DEP_W-1:0]      page_stack_index,
   output logic      [7:0]                     interrupt_enable_reg
);
   import ise_pkg::*;

   logic [7:0]              en_reg_q;
   logic [7:0]              page_q;
   logic [NSRC-1:0]         pend_q;
   logic [NSRC-1:0]         evt;
   logic [NSRC-1:0]         en_all;
   logic [DEP_W-1:0]        dep_q;
   logic [LVL_W-1:0]        lvl_stk_q [STK_DEPTH];
   logic [7:0]              pg_stk_q  [STK_DEPTH];
   logic                    req_now;
   logic [SID_W-1:0]        sel_now;
   logic [LVL_W-1:0]        lvl_now;
   logic                    req_q;
   logic [SID_W-1:0]        sel_q;
   logic [LVL_W-1:0]        lvl_q;
   logic                    take;
   logic [SID_W-1:0]        take_id;
   logic [LVL_W-1:0]        take_lvl;
   logic                    pop;
   logic                    call_q;
   logic [15:0]             vec_q;
   logic [SID_W-1:0]        sid_q;
   logic [7:0]              rdata_q;

   ////////////////////////////////////////////////////////////////////
   // Main enable register, byte and bit writes
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         en_reg_q <= EN_REG_RST;
      end else if (ce) begin
         if (sfr_wr && sfr_addr == EN_REG_ADDR) begin  // R17
            en_reg_q <= sfr_wdata;
         end else if (sfr_bit_wr && sfr_bit_addr[7:3] == EN_REG_ADDR[7:3]) begin
            en_reg_q[sfr_bit_addr[2:0]] <= sfr_bit_val;  // R17
         end
      end
   end

   // Read port; the enable is already clear when the routine reads it
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= 8'h00;
      end else if (ce && sfr_rd) begin
         if (sfr_addr == EN_REG_ADDR) begin
            rdata_q <= en_reg_q;  // R10
         end else if (sfr_addr == PAGE_SEL_ADDR) begin
            rdata_q <= page_q;
         end else begin
            rdata_q <= 8'h00;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Per-source enables; main bits follow the source index
   assign en_all = {extended_enable_reg_two, extended_enable_reg_one,
                    en_reg_q[SPI_EN_BIT:EXT0_EN_BIT]}  // R05 R13 R14 R15 R16
                   & {NSRC{en_reg_q[GLOBAL_EN_BIT]}};  // R06

   // Pending flags; a new event wins over a clear in the same cycle
   for (genvar i = 0; i < NSRC; i++) begin : g_pend
      logic clr;
      if (i == T2_EN_BIT) begin : g_t2
         assign evt[i] = src_evt[i] | timer2_low_overflow_flag
                         | timer2_high_overflow_flag;  // R13
      end else begin : g_oth
         assign evt[i] = src_evt[i];
      end
      assign clr = pend_clr[i] | (take && AUTO_CLR[i]
                   && take_id == SID_W'(i));  // R11
      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            pend_q[i] <= 1'b0;
         end else if (ce) begin
            pend_q[i] <= evt[i] | (pend_q[i] & ~clr);  // R01
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Priority pick: only levels above the one in service may enter
   always_comb begin
      logic [LVL_W-1:0] p;
      logic             open;
      p = '0;
      open = 1'b0;
      req_now = 1'b0;
      sel_now = '0;
      lvl_now = '0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         p = src_prio[i*LVL_W +: LVL_W];  // R07
         open = (dep_q == '0) || (p > lvl_stk_q[dep_q[1:0] - 2'd1]);
         if (pend_q[i] && en_all[i] && open && dep_q < DEP_W'(STK_DEPTH)  // R04
             && (!req_now || p >= lvl_now)) begin  // R20
            req_now = 1'b1;
            sel_now = SID_W'(i);
            lvl_now = p;
         end
      end
   end

   // Request seen one cycle back survives an enable clear
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         req_q <= 1'b0;
         sel_q <= '0;
         lvl_q <= '0;
      end else if (ce) begin
         req_q <= req_now;
         sel_q <= sel_now;
         lvl_q <= lvl_now;
      end
   end

   // Taken at an instruction end, never at the end of a return
   assign take = instr_done && !return_from_isr
                 && (req_now || (req_q && !next_multi_cycle));  // R08 R12
   assign take_id  = req_now ? sel_now : sel_q;
   assign take_lvl = req_now ? lvl_now : lvl_q;
   assign pop = return_from_isr && dep_q != '0;

   ////////////////////////////////////////////////////////////////////
   // Vector call strobe and address
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         call_q <= 1'b0;
         vec_q  <= 16'h0000;
         sid_q  <= '0;
      end else if (ce) begin
         call_q <= take;  // R02
         if (take) begin
            sid_q <= take_id;
            vec_q <= VEC_BASE + 16'(VEC_STEP * take_id);  // R02
         end
      end
   end

   // Page stack entries, one per nesting level
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         for (int k = 0; k < STK_DEPTH; k++) begin
            lvl_stk_q[k] <= '0;
            pg_stk_q[k]  <= PAGE_RST;
         end
      end else if (ce && take) begin
         lvl_stk_q[dep_q[1:0]] <= take_lvl;
         pg_stk_q[dep_q[1:0]]  <= page_q;  // R18
      end
   end

   // Stack depth; return lands on the instruction after the call
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         dep_q <= '0;
      end else if (ce) begin
         if (take) begin
            dep_q <= dep_q + DEP_W'(1);
         end else if (pop) begin
            dep_q <= dep_q - DEP_W'(1);  // R03
         end
      end
   end

   // Page select is the stack top; hardware moves beat software writes
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         page_q <= PAGE_RST;
      end else if (ce) begin
         if (take) begin
            page_q <= ISR_PAGE;  // R18
         end else if (pop) begin
            page_q <= pg_stk_q[dep_q[1:0] - 2'd1];  // R21
         end else if (sfr_wr && sfr_addr == PAGE_SEL_ADDR) begin
            page_q <= sfr_wdata;  // R19
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs, all from flip-flops
   assign sfr_rdata            = rdata_q;
   assign irq_req              = req_q;
   assign vector_call          = call_q;
   assign vec_addr             = vec_q;
   assign src_id               = sid_q;
   assign pending              = pend_q;
   assign register_page_select = page_q;
   assign page_stack_index     = dep_q;
   assign interrupt_enable_reg = en_reg_q;

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   property p_pend_set;
      ce |=> ((pend_q & $past(evt)) == $past(evt));
   endproperty
   a_pend_set: assert property (p_pend_set) else $error("event lost"); // R01

   property p_gbl_off;
      ce && !en_reg_q[GLOBAL_EN_BIT] |=> !irq_req;
   endproperty
   a_gbl_off: assert property (p_gbl_off) else $error("request while off"); // R06

   property p_no_en;
      ce && (pend_q & en_all) == '0 |=> !irq_req;
   endproperty
   a_no_en: assert property (p_no_en) else $error("masked request"); // R04

   property p_call_cause;
      vector_call |-> $past(instr_done) && !$past(return_from_isr) && $past(ce);
   endproperty
   a_call_cause: assert property (p_call_cause) else $error("stray call"); // R02

   property p_vec;
      vector_call |-> vec_addr == VEC_BASE + 16'(VEC_STEP * src_id);
   endproperty
   a_vec: assert property (p_vec) else $error("bad vector"); // R02

   property p_push;
      vector_call |-> register_page_select == ISR_PAGE
         && page_stack_index == $past(page_stack_index) + DEP_W'(1);
   endproperty
   a_push: assert property (p_push) else $error("no push"); // R18

   property p_pop;
      ce && return_from_isr && dep_q != '0 |=> page_stack_index == $past(dep_q) - DEP_W'(1)
         && page_q == $past(pg_stk_q[dep_q[1:0] - 2'd1]);
   endproperty
   a_pop: assert property (p_pop) else $error("no pop"); // R21

   property p_multi;
      ce && instr_done && next_multi_cycle && !req_now |=> !vector_call;
   endproperty
   a_multi: assert property (p_multi) else $error("call after clear"); // R08

   property p_ret_gap;
      ce && return_from_isr |=> !vector_call;
   endproperty
   a_ret_gap: assert property (p_ret_gap) else $error("call on return"); // R12

   property p_auto;
      vector_call && AUTO_CLR[src_id] && !$past(evt[take_id]) |-> !pend_q[src_id];
   endproperty
   a_auto: assert property (p_auto) else $error("flag not cleared"); // R11

   property p_bit_wr;
      ce && sfr_bit_wr && !sfr_wr && sfr_bit_addr == EN_REG_ADDR + 8'h07 && !sfr_bit_val
         |=> !interrupt_enable_reg[GLOBAL_EN_BIT];
   endproperty
   a_bit_wr: assert property (p_bit_wr) else $error("bit write lost"); // R17

   c_call: cover property (vector_call);
   c_nest: cover property (vector_call && page_stack_index == DEP_W'(2));
   c_slip: cover property (ce && take && !req_now);
   c_ret:  cover property (ce && pop);
endmodule

/* rtl/ise_pkg.sv */
// Constants shared by the interrupt entry logic: register addresses,
// field positions, reset values, source map and vector layout.
// Assumes a byte-wide special-register port driven by the CPU core.
package ise_pkg;
   // Source counts and widths
   localparam int NMAIN = 7;
   localparam int NEXT  = 16;
   localparam int NSRC  = NMAIN + NEXT;
   localparam int LVL_W = 2;
   localparam int SID_W = 5;
   localparam int STK_DEPTH = 4;
   localparam int DEP_W = 3;
   // Register addresses
   localparam logic [7:0] EN_REG_ADDR   = 8'hA8;
   localparam logic [7:0] PAGE_SEL_ADDR = 8'hA7;
   // Reset values
   localparam logic [7:0] EN_REG_RST = 8'h00;
   localparam logic [7:0] PAGE_RST   = 8'h00;
   // Enable register field positions
   localparam int GLOBAL_EN_BIT = 7;
   localparam int SPI_EN_BIT    = 6;
   localparam int T2_EN_BIT     = 5;
   localparam int UART_EN_BIT   = 4;
   localparam int T1_EN_BIT     = 3;
   localparam int EXT1_EN_BIT   = 2;
   localparam int T0_EN_BIT     = 1;
   localparam int EXT0_EN_BIT   = 0;
   // Sources whose pending flag clears itself on vectoring
   localparam logic [NSRC-1:0] AUTO_CLR = 23'h00000F;
   // Vector table and page loaded on entry
   localparam logic [15:0] VEC_BASE = 16'h0003;
   localparam logic [15:0] VEC_STEP = 16'h0008;
   localparam logic [7:0]  ISR_PAGE = 8'h00;
endpackage
